// ==== hdl/reset_cause_flag_register.sv ====
`timescale 1ns/1ps
module reset_cause_flag_register (
    input  wire logic                                pclk,                 // 200 MHz clock
    input  wire logic                                presetn,              // Async reset, low
    input  wire logic [reset_cause_pkg::ADDR_W-1:0]  paddr,                // APB address
    input  wire logic                                psel,                 // APB select
    input  wire logic                                penable,              // APB enable
    input  wire logic                                pwrite,               // APB direction
    input  wire logic [reset_cause_pkg::DATA_W-1:0]  pwdata,               // APB write data
    input  wire logic [3:0]                          pstrb,                // APB byte strobes
    output logic      [reset_cause_pkg::DATA_W-1:0]  prdata,               // APB read data
    output logic                                     pready,               // APB ready
    output logic                                     pslverr,              // APB error
    input  wire reset_cause_pkg::reset_events_s      events,               // Reset/power pulses
    input  wire logic                                fuse_watchdog_enable, // Config fuse level
    output logic                                     watchdog_run,         // Watchdog enabled
    output logic                                     regulator_standby_select, // Regulator in sleep
    output logic                                     irq                   // Level interrupt
);

    localparam int unsigned RW = reset_cause_pkg::REG_W;

    logic [RW-1:0] control_reg;
    logic [RW-1:0] control_next;
    logic [RW-1:0] irq_status_reg;
    logic [RW-1:0] irq_status_next;
    logic [RW-1:0] irq_enable_reg;
    logic [RW-1:0] irq_enable_next;
    logic [RW-1:0] hw_set;
    logic [RW-1:0] read_word;
    logic [reset_cause_pkg::DATA_W-1:0] prdata_reg;
    logic          fuse_meta_reg;
    logic          fuse_sync_reg;
    logic          setup;
    logic          access;
    logic          wr_en;
    logic          hit_control;
    logic          hit_status;
    logic          hit_clear;
    logic          hit_enable;
    logic          mapped;

    // Merge a 16-bit register with the low two byte lanes of a write
    function automatic logic [RW-1:0] merge_lanes(
        input logic [RW-1:0]                         old_val,
        input logic [reset_cause_pkg::DATA_W-1:0]    wdata,
        input logic [3:0]                            strb
    );
        logic [RW-1:0] res;
        res = old_val;
        if (strb[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : merge_lanes

    // Bits of a clear-register write, gated by byte lanes
    function automatic logic [RW-1:0] lane_bits(
        input logic [reset_cause_pkg::DATA_W-1:0]    wdata,
        input logic [3:0]                            strb
    );
        logic [RW-1:0] res;
        res = {RW{1'b0}};
        if (strb[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : lane_bits

    // APB decode; zero wait states, so access always completes
    assign setup       = psel & ~penable;
    assign access      = psel & penable;
    assign wr_en       = access & pwrite;
    assign hit_control = (paddr == reset_cause_pkg::OFS_CONTROL);
    assign hit_status  = (paddr == reset_cause_pkg::OFS_IRQ_STATUS);
    assign hit_clear   = (paddr == reset_cause_pkg::OFS_IRQ_CLEAR);
    assign hit_enable  = (paddr == reset_cause_pkg::OFS_IRQ_ENABLE);
    assign mapped      = hit_control | hit_status | hit_clear | hit_enable;
    assign pready      = 1'b1;
    // Writes to the read-only status word are errors too
    assign pslverr     = access & (~mapped | (pwrite & hit_status));
    assign prdata      = prdata_reg;

    // Fuse is a pin-level input from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_meta_reg <= 1'b0;
            fuse_sync_reg <= 1'b0;
        end else begin
            fuse_meta_reg <= fuse_watchdog_enable;
            fuse_sync_reg <= fuse_meta_reg;
        end
    end

    // Flags that hardware sets this cycle
    always_comb begin
        hw_set = {RW{1'b0}};
        hw_set[reset_cause_pkg::BIT_TRAP]    = events.trap_conflict;
        hw_set[reset_cause_pkg::BIT_ILLEGAL] = events.illegal_access;
        hw_set[reset_cause_pkg::BIT_PIN]     = events.pin_reset;
        hw_set[reset_cause_pkg::BIT_SOFT]    = events.soft_reset;
        hw_set[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]    = events.wdt_timeout;
        hw_set[reset_cause_pkg::BIT_SLEEP]   = events.sleep_entry;
        hw_set[reset_cause_pkg::BIT_IDLE]    = events.idle_entry;
        hw_set[reset_cause_pkg::BIT_BOR]     = events.brownout | events.power_on;
        hw_set[reset_cause_pkg::BIT_POR]     = events.power_on;
    end

    // Control register: software write, then hardware clears, then sets.
    // Power-on is a reset of the device, so it overrides any software write
    // landing in the same cycle; brown-out overrides it only in BOR_CLEAR_MASK bits and the brown-out flag.
    always_comb begin
        control_next = control_reg;
        if (wr_en && hit_control) begin
            // Pure storage: nothing here reaches a reset source
            control_next = merge_lanes(control_reg, pwdata, pstrb)
                           & reset_cause_pkg::CONTROL_RW_MASK;
        end
        if (events.sleep_entry || events.idle_entry) begin
            control_next[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end
        control_next = control_next | (hw_set & ~{RW{events.power_on | events.brownout}});
        if (events.brownout) begin
            // Pin reset flag and power-on flag survive a brown-out
            control_next = (control_next & ~reset_cause_pkg::BOR_CLEAR_MASK)
                           | hw_set;
        end
        if (events.power_on) begin
            control_next = reset_cause_pkg::CONTROL_POR_VAL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= reset_cause_pkg::CONTROL_POR_VAL;
        end else begin
            control_reg <= control_next;
        end
    end

    // Soft enable only counts while the fuse is programmed to zero
    assign watchdog_run = fuse_sync_reg
                        | control_reg[reset_cause_pkg::BIT_SWDT];
    assign regulator_standby_select = control_reg[reset_cause_pkg::BIT_VREG];

    // Interrupt status: sticky, write-one-to-clear, set beats clear
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_en && hit_clear) begin
            irq_status_next = irq_status_next & ~lane_bits(pwdata, pstrb);
        end
        irq_status_next = (irq_status_next | hw_set) & reset_cause_pkg::EVENT_MASK;
    end

    always_comb begin
        irq_enable_next = irq_enable_reg;
        if (wr_en && hit_enable) begin
            irq_enable_next = merge_lanes(irq_enable_reg, pwdata, pstrb)
                              & reset_cause_pkg::EVENT_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= {RW{1'b0}};
            irq_enable_reg <= {RW{1'b0}};
        end else begin
            irq_status_reg <= irq_status_next;
            irq_enable_reg <= irq_enable_next;
        end
    end

    assign irq = |(irq_status_reg & irq_enable_reg);

    // Read word selected by address; clear register reads zero
    always_comb begin
        read_word = {RW{1'b0}};
        if (hit_control) begin
            read_word = control_reg;
        end else if (hit_status) begin
            read_word = irq_status_reg;
        end else if (hit_enable) begin
            read_word = irq_enable_reg;
        end
    end

    // Captured in setup so prdata comes from a flop during access.
    // A hardware event in the setup cycle shows on the next read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (setup && !pwrite) begin
            prdata_reg <= {{(reset_cause_pkg::DATA_W-RW){1'b0}}, read_word};
        end
    end

endmodule : reset_cause_flag_register

// ==== hdl/reset_cause_pkg.sv ====
//
// Function
// - Software may write every reset-cause and low-power flag to either value, except where a hardware event in the same cycle overrides it.
// - With the fuse at one the watchdog runs from the second clock edge after reset onward; otherwise the soft enable bit gates it.
// - The watchdog timeout flag (bit 4) sets on time-out, clears on power-save, power-on, brown-out.
// - The illegal access flag (bit 14) sets on an illegal access reset, clears on power-on or brown-out.
// - The pin reset flag (bit 7) sets on a pin reset and hardware clears it only on power-on.
// - A software write only stores the flag value and never causes a device reset.
// - Power-on clears every set flag except the power-on (bit 0) and brown-out (bit 1) flags, which it sets.
package reset_cause_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 16;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFS_CONTROL    = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h00c;

    // Field positions in reset_cause_control
    localparam int unsigned BIT_TRAP    = 15;
    localparam int unsigned BIT_ILLEGAL = 14;
    localparam int unsigned BIT_VREG    = 8;
    localparam int unsigned BIT_PIN     = 7;
    localparam int unsigned BIT_SOFT    = 6;
    localparam int unsigned BIT_SWDT    = 5;
    localparam int unsigned BIT_WATCHDOG_TIMEOUT_FLAG    = 4;
    localparam int unsigned BIT_SLEEP   = 3;
    localparam int unsigned BIT_IDLE    = 2;
    localparam int unsigned BIT_BOR     = 1;
    localparam int unsigned BIT_POR     = 0;

    // Bits 13..9 are unimplemented and read as zero
    localparam logic [REG_W-1:0] CONTROL_RW_MASK = 16'hc1ff;
    // Value left by a power-on: power-on and brown-out flags set
    localparam logic [REG_W-1:0] CONTROL_POR_VAL = 16'h0003;
    // Flags that a brown-out clears
    localparam logic [REG_W-1:0] BOR_CLEAR_MASK  = 16'hc05c;
    // Flags that hardware sets; these also feed the interrupt status
    localparam logic [REG_W-1:0] EVENT_MASK      = 16'hc0df;

    typedef struct packed {
        logic power_on;        // Power-on event
        logic brownout;        // Brown-out event
        logic pin_reset;       // Reset from master_clear_pin
        logic soft_reset;      // Reset instruction executed
        logic wdt_timeout;     // watchdog_timer time-out
        logic trap_conflict;   // Trap conflict reset
        logic illegal_access;  // Illegal opcode/address mode/pointer
        logic sleep_entry;     // power_save_instruction, sleep form
        logic idle_entry;      // power_save_instruction, idle form
    } reset_events_s;

endpackage : reset_cause_pkg

// ==== sim/reset_cause_monitor.sv ====
`timescale 1ns/1ps
module reset_cause_monitor (
    input wire logic                          pclk,                     // Clock
    input wire logic                          presetn,                  // Reset, low
    input wire logic [11:0]                   paddr,                    // Address
    input wire logic                          psel,                     // Select
    input wire logic                          penable,                  // Enable
    input wire logic                          pwrite,                   // Direction
    input wire logic [31:0]                   pwdata,                   // Write data
    input wire logic [3:0]                    pstrb,                    // Strobes
    input wire logic                          pslverr,                  // Error
    input wire reset_cause_pkg::reset_events_s events,                  // Event pulses
    input wire logic                          fuse_watchdog_enable,     // Fuse level
    input wire logic                          watchdog_run,             // Watchdog on
    input wire logic                          regulator_standby_select, // Regulator
    input wire logic                          irq                       // Interrupt
);
    logic [1:0] up_cnt;
    logic       wr;
    assign wr = psel && penable && pwrite;
    // Fuse history is meaningless until the synchroniser has refilled after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_FUSE_RUN: assert property (up_cnt == 2'h3 && $past(fuse_watchdog_enable, 2)
        |-> watchdog_run) else $error("watchdog off with fuse set");
    AST_WDT_FELL: assert property ($fell(watchdog_run)
        |-> !$past(fuse_watchdog_enable, 2)) else $error("watchdog stopped with fuse set");
    AST_REG_CHANGE: assert property ($changed(regulator_standby_select)
        |-> $past(wr && paddr == 12'h000 || events.power_on)) else $error("regulator moved alone");
    AST_REG_WRITE: assert property (wr && paddr == 12'h000 && pstrb[1] && !events.power_on
        |=> regulator_standby_select == $past(pwdata[8])) else $error("regulator write lost");
    AST_POR_RUN: assert property (up_cnt == 2'h3 && events.power_on
        |=> watchdog_run == $past(fuse_watchdog_enable, 2)) else $error("power-on kept enable");
    AST_CTRL_IRQ: assert property (wr && paddr == 12'h000 && events == '0
        |=> irq == $past(irq)) else $error("control write moved irq");
    AST_IRQ_ROSE: assert property ($rose(irq)
        |-> $past(events != '0 || wr && paddr == 12'h00c)) else $error("irq rose without cause");
    AST_IRQ_CLEAR: assert property (wr && paddr == 12'h008 && pwdata[15:0] == 16'hffff
        && pstrb[1:0] == 2'h3 && events == '0 |=> !irq) else $error("irq survived clear");
    AST_STATUS_RO: assert property (wr && paddr == 12'h004 |-> pslverr)
        else $error("status write accepted");
    cover property (events.power_on);
    cover property ($rose(irq));
    cover property (psel && penable && pslverr);
endmodule : reset_cause_monitor

bind reset_cause_flag_register reset_cause_monitor mon (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb, .pslverr, .events, .fuse_watchdog_enable,
    .watchdog_run, .regulator_standby_select, .irq);

// ==== sim/tb_reset_cause_flag_register.sv ====
`timescale 1ns/1ps
module tb_reset_cause_flag_register;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fuse_watchdog_enable = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, watchdog_run, regulator_standby_select, irq, err;
    reset_cause_pkg::reset_events_s events = '0;
    int          n_errors = 0;
    int          checks_done = 0;
    // Start value, event pulse, expected control value
    logic [15:0] t_init [12] = '{0, 0, 0, 0, 0, 0, 0, 16'hc1fc, 16'h10, 16'h10, 16'h10, 16'hc1fc};
    logic [8:0]  t_ev [12] = '{1, 2, 4, 8, 9'h10, 9'h20, 9'h40, 9'h80, 2, 1, 9'h12, 9'h100};
    logic [15:0] t_exp [12] = '{16'h4, 16'h8, 16'h4000, 16'h8000, 16'h10, 16'h40, 16'h80,
                                16'h1a2, 16'h8, 16'h4, 16'h18, 16'h3};
    always #2.5 pclk = ~pclk;
    reset_cause_flag_register dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .events, .fuse_watchdog_enable, .watchdog_run,
        .regulator_standby_select, .irq);
    task test_done;
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait limit here: a slave that never answers is caught by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rc
    task pulse(input logic [8:0] ev);
        @(posedge pclk);
        events <= ev;
        @(posedge pclk);
        events <= '0;
    endtask : pulse
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(12'h000, 32'h3);
        apb(1'b1, 12'h000, 32'hffff);
        rc(12'h000, 32'hc1ff);
        chk({30'h0, watchdog_run, regulator_standby_select}, 32'h3);
        apb(1'b1, 12'h000, 32'h0);
        rc(12'h000, 32'h0);
        chk({30'h0, watchdog_run, regulator_standby_select}, 32'h0);
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, 12'h000, {16'h0, t_init[i]});
            pulse(t_ev[i]);
            rc(12'h000, {16'h0, t_exp[i]});
        end
        chk({31'h0, regulator_standby_select}, 32'h0);
        fuse_watchdog_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, watchdog_run}, 32'h1);
        fuse_watchdog_enable <= 1'b0;
        apb(1'b1, 12'h008, 32'hffff);
        rc(12'h004, 32'h0);
        apb(1'b1, 12'h00c, 32'h10);
        pulse(9'h10);
        rc(12'h004, 32'h10);
        apb(1'b1, 12'h000, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h00c, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h00c, 32'h10);
        apb(1'b1, 12'h008, 32'h10);
        rc(12'h004, 32'h0);
        pstrb <= 4'h1;
        apb(1'b1, 12'h000, 32'hffff);
        pstrb <= 4'hf;
        rc(12'h000, 32'hff);
        chk({31'h0, watchdog_run}, 32'h1);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rc(12'h000, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h004, 32'hffff);
        chk({31'h0, err}, 32'h1);
        test_done();
    end
    // The sequence needs under two hundred cycles; this margin only catches a hang
    initial begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        test_done();
    end
endmodule : tb_reset_cause_flag_register
